// [dv/hsc_enc_model.sv]
/*
 * hsc_enc_model: incremental pulse source on the eight input terminals.
 * Assumes the bench calls its tasks; gap may be changed between steps.
 */
`timescale 1ns/1ns
module hsc_enc_model (
	input  wire logic       aclk,
	output logic [7:0]      pins
);
	// cycles held after each change; the pin filter needs about four
	int gap = 8;

	initial pins = 8'h00;

	task automatic set_pin(input int i, input logic v);
		@(posedge aclk);
		pins[i] <= v;
		repeat (gap) @(posedge aclk);
	endtask

	task automatic pulse(input int i);
		set_pin(i, 1'b1);
		set_pin(i, 0);
	endtask

	// forward: phase a leads phase b
	task automatic quad(input int a, input int b, input logic fwd);
		set_pin(fwd ? a : b, 1'b1);
		set_pin(fwd ? b : a, 1'b1);
		set_pin(fwd ? a : b, 1'b0);
		set_pin(fwd ? b : a, 1'b0);
	endtask
endmodule // hsc_enc_model

// [dv/hsc_top_assertions.sv]
/*
 * hsc_top_assertions: register port checker of the counter bank.
 * Assumes a bind to hsc_top and ce dropped only while the port is idle.
 */
`timescale 1ns/1ns
module hsc_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_b_late;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence

	a_write_answer: assert property (s_wr_take |=> s_b_late)
		else $error("write answer off time");
	a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read answer missing");
	a_aw_busy: assert property (
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address ready after take");
	a_ar_busy: assert property (s_rd_take |=> !s_axi_arready)
		else $error("read address ready after take");
	a_b_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_r_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_unmapped_read: assert property (
		s_rd_take ##0 s_axi_araddr == 8'h18
		|=> s_axi_rresp == hsc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_reset_idle: assert property ($rose(aresetn) |->
		!s_axi_bvalid && !s_axi_rvalid && !s_axi_awready)
		else $error("port busy out of reset");
endmodule // hsc_chk

bind hsc_top hsc_chk u_hsc_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// [dv/testbench.sv]
/*
 * testbench: self-checking bench of the pulse counter bank.
 * Assumes hsc_enc_model drives the terminals and the checker is bound.
 */
`timescale 1ns/1ns
module testbench;
	logic        aclk;
	logic        aresetn;
	logic        ce;
	logic [7:0]  pins;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic [31:0] seed;
	logic [31:0] n;
	logic [31:0] v;
	int          n_mismatch;
	int          check_count;
	int          cycles;

	hsc_top u_hsc_top (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.pulse_input_terminal(pins), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	hsc_enc_model u_enc (.aclk(aclk), .pins(pins));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// value after c whole quadrature cycles
	function automatic logic [31:0] qexp(input logic [31:0] b,
		input logic four, input logic fwd, input logic [31:0] c);
		return fwd ? b + (four ? c << 2 : c) : b - (four ? c << 2 : c);
	endfunction

	task automatic stop_test();
		if (n_mismatch == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %0t exp %h got %h", $time, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e = hsc_pkg::RESP_OKAY);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (awvalid && !awready || wvalid && !wready);
		// random stall so the response must stand
		seed = xs(seed);
		repeat (seed[1:0]) @(posedge aclk);
		bready <= 1'b1;
		do
			@(posedge aclk);
		while (!bvalid);
		bready <= 1'b0;
		chk({30'h0, e}, {30'h0, bresp});
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = hsc_pkg::RESP_OKAY);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do
			@(posedge aclk);
		while (!arready);
		arvalid <= 1'b0;
		seed = xs(seed);
		repeat (seed[1:0]) @(posedge aclk);
		rready <= 1'b1;
		do
			@(posedge aclk);
		while (!rvalid);
		rready <= 1'b0;
		chk(e, rdata);
		chk({30'h0, er}, {30'h0, rresp});
	endtask

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 40000) begin
			n_mismatch++;
			stop_test();
		end
	end

	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'hf;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		seed = 32'hb3d193e2;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(8'h20, 32'h0);
		rdc(8'h0c, 32'h27);
		wr(8'h04, 32'h1);
		u_enc.set_pin(6, 1'b1);
		seed = xs(seed);
		n = {29'h0, seed[2:0]} + 32'h1;
		repeat (n) u_enc.pulse(0);
		rdc(8'h20, n);
		rdc(8'h10, 32'h4340);
		wr(8'h08, 32'h1);
		repeat (n + 1) u_enc.pulse(0);
		rdc(8'h20, 32'hffff_ffff);
		rdc(8'h0c, 32'h127);
		u_enc.pulse(1);
		rdc(8'h20, 32'h0);
		v = xs(seed);
		wr(8'h20, v);
		wr(8'h00, 32'h3);
		u_enc.set_pin(1, 1'b1);
		rdc(8'h20, v);
		rdc(8'h0c, 32'h137);
		u_enc.set_pin(1, 1'b0);
		rdc(8'h20, 32'h0);
		wr(8'h08, 32'h0);
		// drop the start level first: rerouting a high terminal is an edge
		u_enc.set_pin(6, 1'b0);
		wr(8'h00, 32'h5);
		rdc(8'h0c, 32'h26);
		u_enc.pulse(0);
		repeat (n) u_enc.pulse(6);
		rdc(8'h20, n);
		wr(8'h00, 32'h85);
		rdc(8'h0c, 32'h3f);
		wr(8'h04, 32'h10);
		wr(8'h00, 32'h11);
		rdc(8'h0c, 32'h33);
		v = xs(v);
		wr(8'h30, v);
		u_enc.pulse(5);
		rdc(8'h30, v);
		wr(8'h00, 32'h0);
		u_enc.pulse(5);
		rdc(8'h30, 32'h0);
		wr(8'h04, 32'h8);
		u_enc.gap = 6 + int'(seed[2:0]);
		repeat (n + 1) u_enc.quad(0, 1, 1'b1);
		u_enc.quad(0, 1, 1'b0);
		v = qexp(n + 32'h1, 1'b0, 1'b0, 32'h1);
		rdc(8'h2c, v);
		rdc(8'h0c, 32'h827);
		wr(8'h00, 32'h21);
		repeat (n) u_enc.quad(0, 1, 1'b1);
		v = qexp(v, 1'b1, 1'b1, n);
		rdc(8'h2c, v);
		u_enc.quad(0, 1, 1'b0);
		v = qexp(v, 1'b1, 1'b0, 32'h1);
		rdc(8'h2c, v);
		// a whole cycle while frozen must leave no trace
		ce <= 1'b0;
		u_enc.quad(0, 1, 1'b1);
		ce <= 1'b1;
		rdc(8'h2c, v);
		seed = xs(seed);
		v = {v[31:8], seed[7:0]};
		wstrb <= 4'h1;
		wr(8'h2c, seed);
		wstrb <= 4'hf;
		rdc(8'h2c, v);
		wr(8'h04, 32'hc);
		repeat (n + 1) u_enc.pulse(3);
		u_enc.pulse(4);
		rdc(8'h28, n);
		rdc(8'h0c, 32'hc27);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(8'h2c, 32'h0);
		rdc(8'h00, 32'h0);
		wr(8'h18, v, hsc_pkg::RESP_SLVERR);
		rdc(8'h18, 32'h0, hsc_pkg::RESP_SLVERR);
		stop_test();
	end
endmodule // testbench

// [verilog/hsc_cnt_if.sv]
/*
 * hsc_cnt_if: routing and result bundle between the bank and one counter.
 * Assumes hsc_pkg compiled first.
 */
`timescale 1ns/1ns
interface hsc_cnt_if;
	logic                    a_in;
	logic                    b_in;
	logic                    rst_in;
	logic                    start_in;
	logic                    use_rst;
	logic                    use_start;
	logic                    rst_inv;
	logic                    enable;
	logic                    four_edge;
	logic                    dir_relay;
	logic                    load_en;
	hsc_pkg::hsc_mode_t      mode;
	logic [hsc_pkg::CNT_W-1:0] load_val;
	logic [hsc_pkg::CNT_W-1:0] value;
	logic                    down;

	modport ctl (
		output a_in, b_in, rst_in, start_in, use_rst, use_start, rst_inv,
		output enable, four_edge, dir_relay, load_en, mode, load_val,
		input  value, down
	);
	modport cnt (
		input  a_in, b_in, rst_in, start_in, use_rst, use_start, rst_inv,
		input  enable, four_edge, dir_relay, load_en, mode, load_val,
		output value, down
	);
endinterface // hsc_cnt_if

// [verilog/hsc_counter.sv]
/*
 * hsc_counter: one 32-bit up/down counter, single-phase or quadrature.
 * Assumes inputs already synchronised and filtered on aclk.
 */
`timescale 1ns/1ns
module hsc_counter (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	hsc_cnt_if.cnt   bus
);
	logic                      a_q, a_d, b_q, b_d, r_q, r_d;
	logic                      down_q, down_d;
	logic [hsc_pkg::CNT_W-1:0] val_q, val_d;
	logic                      step, dn, rst_hit, run;

	always_comb begin
		a_d    = bus.a_in;
		b_d    = bus.b_in;
		r_d    = bus.rst_in;
		down_d = down_q;
		val_d  = val_q;
		step   = 1'b0;
		dn     = down_q;
		run    = bus.enable && (!bus.use_start || bus.start_in);
		rst_hit = bus.use_rst && (bus.rst_inv ? (r_q && !bus.rst_in)
		                                      : (!r_q && bus.rst_in));
		unique case (bus.mode)
		hsc_pkg::HSC_SP1: begin
			dn   = bus.dir_relay;
			step = bus.a_in && !a_q;
		end
		hsc_pkg::HSC_SP2: begin
			// coincident up and down edges cancel
			step = (bus.a_in && !a_q) != (bus.b_in && !b_q);
			dn   = bus.b_in && !b_q;
		end
		hsc_pkg::HSC_QUAD: begin
			if (bus.four_edge) begin
				step = (bus.a_in != a_q) != (bus.b_in != b_q);
				dn   = a_q ^ bus.b_in;
			end else begin
				step = bus.a_in && !a_q;
				dn   = bus.b_in;
			end
		end
		default: step = 1'b0;
		endcase
		step = step && run;
		if (bus.mode == hsc_pkg::HSC_SP1)
			down_d = bus.dir_relay;
		else if (step)
			down_d = dn;
		if (rst_hit)
			val_d = hsc_pkg::CNT_RST;
		else if (bus.load_en)
			val_d = bus.load_val;
		else if (step)
			val_d = dn ? val_q - 32'h1 : val_q + 32'h1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_q    <= 1'b0;
			b_q    <= 1'b0;
			r_q    <= 1'b0;
			down_q <= 1'b0;
			val_q  <= hsc_pkg::CNT_RST;
		end else if (ce) begin
			a_q    <= a_d;
			b_q    <= b_d;
			r_q    <= r_d;
			down_q <= down_d;
			val_q  <= val_d;
		end
	end

	assign bus.value = val_q;
	assign bus.down  = down_q;
endmodule // hsc_counter

// [verilog/hsc_pkg.sv]
/*
 * hsc_pkg: shared constants and types of the high speed pulse counter bank.
 * Assumes one 100 MHz clock domain and an AXI4-Lite register port.
 */
package hsc_pkg;

	localparam int NUM_TERM = 8;
	localparam int NUM_CNT  = 6;
	localparam int CNT_W    = 32;
	localparam int DATA_W   = 32;
	localparam int ADDR_W   = 8;

	// byte offsets of the register map
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_ENABLE   = 8'h04;
	localparam logic [7:0] OFF_DIR      = 8'h08;
	localparam logic [7:0] OFF_STATUS   = 8'h0c;
	localparam logic [7:0] OFF_INPUTS   = 8'h10;
	localparam logic [7:0] OFF_CNT_BASE = 8'h20;

	// control register bit positions
	localparam int BIT_FUNC_CHANGE = 0;
	localparam int BIT_RST_POL     = 1;
	localparam int BIT_HW_SW_A     = 2;
	localparam int BIT_HW_SW_B     = 3;
	localparam int BIT_HW_SW_C     = 4;
	localparam int BIT_EDGE_MUL_A  = 5;
	localparam int BIT_EDGE_MUL_B  = 6;
	localparam int BIT_CMP_ACTIVE  = 7;

	// status and input register field positions
	localparam int POS_DOWN    = 8;
	localparam int POS_CLAIMED = 8;

	// counter slots
	localparam int CNT_SP1_START_A = 0;
	localparam int CNT_SP1_START_B = 1;
	localparam int CNT_SP2_RESET   = 2;
	localparam int CNT_QUAD_BASIC  = 3;
	localparam int CNT_QUAD_HW_RST = 4;
	localparam int CNT_QUAD_START  = 5;

	// values after reset
	localparam logic [7:0]       CTRL_RST   = 8'h00;
	localparam logic [5:0]       ENABLE_RST = 6'h00;
	localparam logic [5:0]       DIR_RST    = 6'h00;
	localparam logic [CNT_W-1:0] CNT_RST    = 32'h0000_0000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		HSC_SP1  = 3'h1,
		HSC_SP2  = 3'h2,
		HSC_QUAD = 3'h4
	} hsc_mode_t;

	typedef enum logic [1:0] {
		HSC_W_IDLE = 2'h1,
		HSC_W_RESP = 2'h2
	} hsc_wst_t;

	typedef enum logic [1:0] {
		HSC_R_IDLE = 2'h1,
		HSC_R_DATA = 2'h2
	} hsc_rst_t;

endpackage

// [verilog/hsc_top.sv]
/*
 * hsc_top: bank of six high speed pulse counters on eight shared input
 * terminals, with an AXI4-Lite register slave.
 * Assumes one clock aclk, synchronous active-low reset, asynchronous pins.
 */
// Our own choices: the address map and register access over AXI4-Lite.
//
// Summary of operation
// - counters take their inputs from the eight shared input terminals.
// - each counter holds a 32-bit value counting up or down.
// - a single-input counter counts down while its direction relay is set.
// - a quadrature counter picks its own direction and reports it.
// - quadrature counts one edge, four edges when both relays are set.
// - external reset clears on turn-on, on turn-off when inverted.
// - the two single-phase start counters and one two-input counter switch to hardware.
// - one quadrature counter becomes a no-reset software variant.
// - hardware counters fall back to software under comparison use.
`timescale 1ns/1ns
module hsc_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [7:0]  pulse_input_terminal,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	localparam int NC = hsc_pkg::NUM_CNT;

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int k = 0; k < 4; k++)
			if (strb[k])
				r[8*k +: 8] = new_v[8*k +: 8];
		return r;
	endfunction

	function automatic logic cnt_hit(input logic [7:0] addr);
		return addr[7:2] >= hsc_pkg::OFF_CNT_BASE[7:2] &&
		       addr[7:2] < hsc_pkg::OFF_CNT_BASE[7:2] + 6'(NC);
	endfunction

	function automatic logic [2:0] cnt_idx(input logic [7:0] addr);
		logic [5:0] d;
		d = addr[7:2] - hsc_pkg::OFF_CNT_BASE[7:2];
		return d[2:0];
	endfunction

	// input synchroniser and agreement filter
	logic [7:0] s1_q, s2_q, s3_q, flt_q, flt_d;

	always_comb begin
		// a level moves only once stages two and three agree
		flt_d = (flt_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q  <= 8'h00;
			s2_q  <= 8'h00;
			s3_q  <= 8'h00;
			flt_q <= 8'h00;
		end else if (ce) begin
			s1_q  <= pulse_input_terminal;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			flt_q <= flt_d;
		end
	end

	// software-visible relays
	logic [7:0]  ctrl_q, ctrl_d;
	logic [5:0]  en_q, en_d, dir_q, dir_d;
	logic [5:0]  load_en;
	logic [31:0] load_val;

	// terminal routing
	logic            fc, op_a, op_b, op_c, cmp;
	logic [NC-1:0]   m_a, m_b, m_r, m_s, m_ur, m_us, m_four;
	hsc_pkg::hsc_mode_t m_mode [NC];
	logic [7:0]      use_mask [NC];
	logic [7:0]      claimed;
	logic [5:0]      sw_impl;

	always_comb begin
		fc   = ctrl_q[hsc_pkg::BIT_FUNC_CHANGE];
		op_a = fc && ctrl_q[hsc_pkg::BIT_HW_SW_A];
		op_b = fc && ctrl_q[hsc_pkg::BIT_HW_SW_B];
		op_c = fc && ctrl_q[hsc_pkg::BIT_HW_SW_C];
		cmp  = ctrl_q[hsc_pkg::BIT_CMP_ACTIVE];
		m_a = '0; m_b = '0; m_r = '0; m_s = '0;
		m_ur = '0; m_us = '0; m_four = '0;
		for (int i = 0; i < NC; i++) begin
			m_mode[i]   = hsc_pkg::HSC_QUAD;
			use_mask[i] = 8'h00;
		end
		m_mode[0] = hsc_pkg::HSC_SP1;
		if (op_a) begin
			m_a[0] = flt_q[6];
			use_mask[0] = 8'h40;
		end else begin
			m_a[0] = flt_q[0];
			m_r[0] = flt_q[1];
			m_s[0] = flt_q[6];
			m_ur[0] = 1'b1;
			m_us[0] = 1'b1;
			use_mask[0] = 8'h43;
		end
		m_mode[1] = hsc_pkg::HSC_SP1;
		if (op_b) begin
			m_a[1] = flt_q[7];
			use_mask[1] = 8'h80;
		end else begin
			m_a[1] = flt_q[2];
			m_r[1] = flt_q[3];
			m_s[1] = flt_q[7];
			m_ur[1] = 1'b1;
			m_us[1] = 1'b1;
			use_mask[1] = 8'h8c;
		end
		m_mode[2] = hsc_pkg::HSC_SP2;
		m_a[2] = flt_q[3];
		m_b[2] = flt_q[4];
		m_r[2] = flt_q[5];
		m_ur[2] = !op_c;
		use_mask[2] = op_c ? 8'h18 : 8'h38;
		m_a[3] = flt_q[0];
		m_b[3] = flt_q[1];
		m_four[3] = fc && ctrl_q[hsc_pkg::BIT_EDGE_MUL_A];
		use_mask[3] = 8'h03;
		m_a[4] = flt_q[3];
		m_b[4] = flt_q[4];
		m_r[4] = flt_q[5];
		m_ur[4] = !op_c;
		m_four[4] = fc && ctrl_q[hsc_pkg::BIT_EDGE_MUL_B];
		use_mask[4] = op_c ? 8'h18 : 8'h38;
		m_a[5] = flt_q[0];
		m_b[5] = flt_q[1];
		m_r[5] = flt_q[2];
		m_s[5] = flt_q[6];
		m_ur[5] = 1'b1;
		m_us[5] = 1'b1;
		m_four[5] = fc && ctrl_q[hsc_pkg::BIT_EDGE_MUL_A];
		use_mask[5] = 8'h47;
		claimed = 8'h00;
		for (int i = 0; i < NC; i++)
			if (en_q[i])
				claimed = claimed | use_mask[i];
		// software fallback
		// comparison use pulls every hardware variant back to software
		sw_impl[0] = !op_a || cmp;
		sw_impl[1] = !op_b || cmp;
		sw_impl[2] = !op_c || cmp;
		sw_impl[3] = cmp;
		// an inverted reset also forces the reset variant to software
		sw_impl[4] = cmp || op_c || (fc && ctrl_q[hsc_pkg::BIT_RST_POL]);
		sw_impl[5] = 1'b1;
	end

	hsc_cnt_if cif [NC] ();
	logic [31:0] cnt_val [NC];
	logic [5:0]  cnt_dn;

	for (genvar i = 0; i < NC; i++) begin : g_cnt
		assign cif[i].a_in      = m_a[i];
		assign cif[i].b_in      = m_b[i];
		assign cif[i].rst_in    = m_r[i];
		assign cif[i].start_in  = m_s[i];
		assign cif[i].use_rst   = m_ur[i];
		assign cif[i].use_start = m_us[i];
		assign cif[i].rst_inv   = fc && ctrl_q[hsc_pkg::BIT_RST_POL];
		assign cif[i].enable    = en_q[i];
		assign cif[i].four_edge = m_four[i];
		assign cif[i].dir_relay = dir_q[i];
		assign cif[i].load_en   = load_en[i];
		assign cif[i].load_val  = load_val;
		assign cif[i].mode      = m_mode[i];
		assign cnt_val[i]       = cif[i].value;
		assign cnt_dn[i]        = cif[i].down;
		hsc_counter u_cnt (
			.aclk    (aclk),
			.aresetn (aresetn),
			.ce      (ce),
			.bus     (cif[i].cnt)
		);
	end

	// write channel
	hsc_pkg::hsc_wst_t wst_q, wst_d;
	logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [7:0]  awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic        awready_d, wready_d, bvalid_d;
	logic [1:0]  bresp_d;
	logic [31:0] wm;

	always_comb begin
		wst_d = wst_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = s_axi_bvalid;
		bresp_d = s_axi_bresp;
		ctrl_d = ctrl_q;
		en_d = en_q;
		dir_d = dir_q;
		load_en = 6'h00;
		wm = 32'h0000_0000;
		load_val = merge(cnt_val[cnt_idx(awaddr_q)], wdata_q, wstrb_q);
		if (s_axi_awvalid && s_axi_awready) begin
			awaddr_d = s_axi_awaddr;
			aw_have_d = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
			w_have_d = 1'b1;
		end
		unique case (wst_q)
		hsc_pkg::HSC_W_IDLE: if (aw_have_q && w_have_q) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = hsc_pkg::RESP_OKAY;
			wst_d = hsc_pkg::HSC_W_RESP;
			if (cnt_hit(awaddr_q))
				load_en[cnt_idx(awaddr_q)] = 1'b1;
			else unique case (awaddr_q[7:2])
			hsc_pkg::OFF_CTRL[7:2]: begin
				wm = merge({24'h0, ctrl_q}, wdata_q, wstrb_q);
				ctrl_d = wm[7:0];
			end
			hsc_pkg::OFF_ENABLE[7:2]: begin
				wm = merge({26'h0, en_q}, wdata_q, wstrb_q);
				en_d = wm[5:0];
			end
			hsc_pkg::OFF_DIR[7:2]: begin
				wm = merge({26'h0, dir_q}, wdata_q, wstrb_q);
				dir_d = wm[5:0];
			end
			hsc_pkg::OFF_STATUS[7:2], hsc_pkg::OFF_INPUTS[7:2]: ;
			default: bresp_d = hsc_pkg::RESP_SLVERR;
			endcase
		end
		hsc_pkg::HSC_W_RESP: if (s_axi_bready) begin
			bvalid_d = 1'b0;
			wst_d = hsc_pkg::HSC_W_IDLE;
		end
		endcase
		// address and data are each taken once per write, in any order
		awready_d = wst_d == hsc_pkg::HSC_W_IDLE && !aw_have_d;
		wready_d = wst_d == hsc_pkg::HSC_W_IDLE && !w_have_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_q <= hsc_pkg::HSC_W_IDLE;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= hsc_pkg::RESP_OKAY;
			ctrl_q <= hsc_pkg::CTRL_RST;
			en_q <= hsc_pkg::ENABLE_RST;
			dir_q <= hsc_pkg::DIR_RST;
		end else if (ce) begin
			wst_q <= wst_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			s_axi_awready <= awready_d;
			s_axi_wready <= wready_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_bresp <= bresp_d;
			ctrl_q <= ctrl_d;
			en_q <= en_d;
			dir_q <= dir_d;
		end
	end

	// read channel
	hsc_pkg::hsc_rst_t rst_q, rst_d;
	logic        arready_d, rvalid_d;
	logic [31:0] rdata_d;
	logic [1:0]  rresp_d;

	always_comb begin
		rst_d = rst_q;
		arready_d = s_axi_arready;
		rvalid_d = s_axi_rvalid;
		rdata_d = s_axi_rdata;
		rresp_d = s_axi_rresp;
		unique case (rst_q)
		hsc_pkg::HSC_R_IDLE: if (s_axi_arvalid && s_axi_arready) begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rresp_d = hsc_pkg::RESP_OKAY;
			rdata_d = 32'h0000_0000;
			rst_d = hsc_pkg::HSC_R_DATA;
			if (cnt_hit(s_axi_araddr))
				rdata_d = cnt_val[cnt_idx(s_axi_araddr)];
			else unique case (s_axi_araddr[7:2])
			hsc_pkg::OFF_CTRL[7:2]:   rdata_d[7:0] = ctrl_q;
			hsc_pkg::OFF_ENABLE[7:2]: rdata_d[5:0] = en_q;
			hsc_pkg::OFF_DIR[7:2]:    rdata_d[5:0] = dir_q;
			hsc_pkg::OFF_STATUS[7:2]: begin
				rdata_d[5:0] = sw_impl;
				rdata_d[hsc_pkg::POS_DOWN +: 6] = cnt_dn;
			end
			hsc_pkg::OFF_INPUTS[7:2]: begin
				rdata_d[7:0] = flt_q;
				rdata_d[hsc_pkg::POS_CLAIMED +: 8] = claimed;
			end
			default: rresp_d = hsc_pkg::RESP_SLVERR;
			endcase
		end
		hsc_pkg::HSC_R_DATA: if (s_axi_rready) begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
			rst_d = hsc_pkg::HSC_R_IDLE;
		end
		endcase
		if (rst_q == hsc_pkg::HSC_R_IDLE && !s_axi_arvalid)
			arready_d = 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_q <= hsc_pkg::HSC_R_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= hsc_pkg::RESP_OKAY;
		end else if (ce) begin
			rst_q <= rst_d;
			s_axi_arready <= arready_d;
			s_axi_rvalid <= rvalid_d;
			s_axi_rdata <= rdata_d;
			s_axi_rresp <= rresp_d;
		end
	end
endmodule // hsc_top
